//--- sim/scds_chk_properties.sv
// Concurrent checks on the clock divide control ports.
`timescale 1ns/1ps
module scds_chk
	import scds_pkg::*;
(
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic [7:0] paddr,
	input wire logic       pslverr,
	input wire logic       sys_clk_en,
	input wire logic       mc_clk_en,
	input wire logic       slow_clock_mode,
	input wire logic       multiplier_engaged,
	input wire logic       multiplier_lock_ready,
	input wire logic [1:0] clock_divide_select_eff
);
	logic [1:0]  sc_r;
	logic [10:0] gap_r;
	logic        tick_slow_r;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Counts system ticks and the cycles since the last one.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sc_r        <= 2'h0;
			gap_r       <= 11'h000;
			tick_slow_r <= 1'b0;
		end
		else if (sys_clk_en)
		begin
			sc_r        <= sc_r + 2'h1;
			gap_r       <= 11'h000;
			tick_slow_r <= slow_clock_mode;
		end
		else
			gap_r <= gap_r + 11'h001;
	end

	slverr_decode_a: assert property (pslverr == (psel && penable && paddr != ADDR_MODE &&
		paddr != ADDR_MCTL && paddr != ADDR_STAT)) else $error("error flag decode wrong");
	slow_flag_a: assert property (slow_clock_mode == (clock_divide_select_eff == SEL_SLOW))
		else $error("slow flag disagrees with select");
	mc_quarter_a: assert property (mc_clk_en == (sys_clk_en && sc_r == 2'h3))
		else $error("machine tick not every fourth system tick");
	eff_boundary_a: assert property ($changed(clock_divide_select_eff) |-> $past(mc_clk_en))
		else $error("select changed off a machine cycle boundary");
	engage_cond_a: assert property (multiplier_engaged |->
		clock_divide_select_eff == SEL_MULT && multiplier_lock_ready) else $error("bad engage");
	slow_period_a: assert property (sys_clk_en && slow_clock_mode && tick_slow_r |->
		gap_r == 11'h3ff) else $error("slow tick period wrong");
	via_div4_a: assert property ($changed(clock_divide_select_eff) |->
		clock_divide_select_eff == SEL_DIV4 || $past(clock_divide_select_eff) == SEL_DIV4)
		else $error("select skipped divide-by-4");
	mult_rate_a: assert property (multiplier_engaged [*3] |->
		sys_clk_en || $past(sys_clk_en)) else $error("multiplied tick too slow");
endmodule

bind scds_top scds_chk chk_u (.pclk, .presetn, .psel, .penable, .paddr, .pslverr, .sys_clk_en,
	.mc_clk_en, .slow_clock_mode, .multiplier_engaged, .multiplier_lock_ready,
	.clock_divide_select_eff);

//--- sim/scds_evt_src.sv
// Model of the interrupt and serial sources that request switchback.
`timescale 1ns/1ps
module scds_evt_src
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       fire,
	input  wire logic [2:0] kind,
	output logic            ext_irq_ack,
	output logic            ext_irq_enabled,
	output logic            higher_prio_busy,
	output logic            serial_rx_enabled,
	output logic            serial_start_det,
	output logic            serial_tx_buffer_wr
);
	// Each request gives one event cycle with its qualifying levels; kinds 0, 1 and 5 must not count.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext_irq_ack         <= 1'b0;
			ext_irq_enabled     <= 1'b0;
			higher_prio_busy    <= 1'b0;
			serial_rx_enabled   <= 1'b0;
			serial_start_det    <= 1'b0;
			serial_tx_buffer_wr <= 1'b0;
		end
		else
		begin
			ext_irq_ack         <= fire && kind <= 3'h2;
			ext_irq_enabled     <= fire && kind != 3'h0;
			higher_prio_busy    <= fire && kind == 3'h1;
			serial_rx_enabled   <= fire && kind == 3'h3;
			serial_start_det    <= fire && (kind == 3'h3 || kind == 3'h5);
			serial_tx_buffer_wr <= fire && kind == 3'h4;
		end
	end
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the clock divide control block.
`timescale 1ns/1ps
module tb_top
	import scds_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, ring, s_act, fire, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [2:0]  kind;
	logic        pready, pslverr, sys_en, mc_en, slow, eng, lock;
	logic        irq_ack, irq_en, busy, rx_en, sdet, txw;
	logic [1:0]  eff;
	int          err_total, n_checks, cyc, n;

	scds_top #(.LOCK_CYCLES(16)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ring_osc_mode_flag(ring), .ext_irq_ack(irq_ack),
		.ext_irq_enabled(irq_en), .higher_prio_busy(busy), .serial_rx_enabled(rx_en),
		.serial_start_det(sdet), .serial_tx_buffer_wr(txw), .serial_active(s_act),
		.sys_clk_en(sys_en), .mc_clk_en(mc_en), .slow_clock_mode(slow),
		.multiplier_engaged(eng), .multiplier_lock_ready(lock), .clock_divide_select_eff(eff));
	scds_evt_src evt_u (.pclk(pclk), .presetn(presetn), .fire(fire), .kind(kind),
		.ext_irq_ack(irq_ack), .ext_irq_enabled(irq_en), .higher_prio_busy(busy),
		.serial_rx_enabled(rx_en), .serial_start_det(sdet), .serial_tx_buffer_wr(txw));

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task summarize;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// ----------------------------------------
	// APB transfer; read data taken at the ready edge
	// ----------------------------------------
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		n = 0;
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, q, exp);
	endtask

	task evt(input logic [2:0] k);
		@(posedge pclk);
		kind <= k;
		fire <= 1'b1;
		@(posedge pclk);
		fire <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask

	task wait_lock;
		q = 32'h0000_0000;
		for (int i = 0; i < 100 && q[0] !== 1'b1; i++)
			apb(1'b0, ADDR_STAT, 32'h0000_0000);
		chk("lock", q[0], 32'h1);
	endtask

	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_total++;
			summarize();
		end
	end

	initial
	begin
		{presetn, psel, penable, pwrite, ring, s_act, fire} = 7'h00;
		{paddr, pwdata, kind} = 43'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rdc(ADDR_MODE, 32'h80, "mode");
		rdc(ADDR_MCTL, 32'h00, "mctl");
		rdc(ADDR_STAT, 32'h10, "stat");
		rdc(8'h0c, 32'h00, "hole");
		chk("slverr", e, 32'h1);
		apb(1'b1, ADDR_MODE, 32'h00);
		rdc(ADDR_MODE, 32'h80, "mode");
		apb(1'b1, ADDR_MODE, 32'hc0);
		for (n = 0; n < 200 && slow !== 1'b1; n++) @(posedge pclk);
		chk("eff", eff, 32'h3);
		apb(1'b1, ADDR_MODE, 32'h00);
		rdc(ADDR_MODE, 32'hc0, "mode");
		for (int k = 0; k < 6; k++)
		begin
			apb(1'b1, ADDR_MODE, 32'he0);
			evt(3'(k));
			rdc(ADDR_MODE, (k >= 2 && k <= 4) ? 32'ha0 : 32'he0, "swb");
		end
		s_act <= 1'b1;
		apb(1'b1, ADDR_MODE, 32'h80);
		rdc(ADDR_MODE, 32'hc0, "mode");
		s_act <= 1'b0;
		apb(1'b1, ADDR_MODE, 32'h80);
		rdc(ADDR_MODE, 32'h80, "mode");
		for (n = 0; n < 5000 && slow !== 1'b0; n++) @(posedge pclk);
		apb(1'b1, ADDR_MCTL, 32'h1);
		wait_lock();
		apb(1'b1, ADDR_MODE, 32'h00);
		rdc(ADDR_MODE, 32'h80, "mode");
		apb(1'b1, ADDR_MCTL, 32'h0);
		apb(1'b1, ADDR_MCTL, 32'h2);
		apb(1'b1, ADDR_MCTL, 32'h3);
		wait_lock();
		chk("lockpin", lock, 32'h1);
		rdc(ADDR_STAT, 32'h111, "stat");
		apb(1'b1, ADDR_MODE, 32'h00);
		rdc(ADDR_MODE, 32'h00, "mode");
		for (n = 0; n < 200 && eng !== 1'b1; n++) @(posedge pclk);
		chk("eng", eng, 32'h1);
		@(posedge pclk);
		chk("tick", sys_en, 32'h1);
		@(posedge pclk);
		chk("tick", sys_en, 32'h1);
		apb(1'b1, ADDR_MODE, 32'hc0);
		rdc(ADDR_MODE, 32'h00, "mode");
		apb(1'b1, ADDR_MODE, 32'h80);
		rdc(ADDR_MODE, 32'h80, "mode");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc(ADDR_MCTL, 32'h00, "mctl");
		summarize();
	end
endmodule

//--- src/scds_clk_if.sv
// Interface carrying the clock selection and the derived tick enables.
`timescale 1ns/1ps
interface scds_clk_if;
	logic [1:0] sel_eff;
	logic       mult_on;
	logic       factor;
	logic       sys_en;
	logic       mc_en;
	logic       osc_en;

	modport gen
	(
		input  sel_eff,
		input  mult_on,
		input  factor,
		output sys_en,
		output mc_en,
		output osc_en
	);

	modport core
	(
		output sel_eff,
		output mult_on,
		output factor,
		input  sys_en,
		input  mc_en,
		input  osc_en
	);
endinterface

//--- src/scds_mult_seq.sv
// Multiplier engagement sequence tracker and lock-ready timer.
`timescale 1ns/1ps
module scds_mult_seq
	import scds_pkg::*;
#(
	parameter int LOCK_CYCLES = LOCK_OSC_CYCLES
)
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       mctl_wr,
	input  wire logic       wr_en_bit,
	input  wire logic       mult_en,
	input  wire logic [1:0] sel_cur,
	input  wire logic       ring_flag,
	input  wire logic       osc_en,
	input  wire logic       engage,
	output logic            mult_ok,
	output logic            lock_ready,
	output scds_seq_t       state
);
	scds_seq_t   state_r;
	scds_seq_t   state_nxt;
	logic [16:0] lock_cnt_r;
	wire         base_ok;
	wire         lock_done;

	assign base_ok   = (sel_cur == SEL_DIV4) && !ring_flag;
	assign lock_done = (lock_cnt_r == 17'(LOCK_CYCLES - 1));
	assign mult_ok   = (state_r == SEQ_READY);
	assign state     = state_r;

	// An enable write out of order sends the tracker to idle; a clear write after enable sends it to cleared.
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			SEQ_IDLE:
				if (mctl_wr && !wr_en_bit)
					state_nxt = SEQ_CLEARED;
			SEQ_CLEARED:
				if (mctl_wr)
					state_nxt = wr_en_bit ? SEQ_IDLE : SEQ_FACTOR;
			SEQ_FACTOR:
				if (mctl_wr && wr_en_bit)
					state_nxt = SEQ_LOCKING;
			SEQ_LOCKING:
				if (mctl_wr)
					state_nxt = wr_en_bit ? SEQ_IDLE : SEQ_CLEARED;
				else if (lock_ready)
					state_nxt = SEQ_READY;
			SEQ_READY:
				if (mctl_wr)
					state_nxt = wr_en_bit ? SEQ_IDLE : SEQ_CLEARED;
			default:
				state_nxt = SEQ_IDLE;
		endcase
		if (!base_ok || engage)
			state_nxt = SEQ_IDLE; // RULE_09
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_r <= SEQ_IDLE;
		else
			state_r <= state_nxt; // RULE_09
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lock_cnt_r <= 17'h00000;
			lock_ready <= 1'b0;
		end
		else if (!mult_en)
		begin
			lock_cnt_r <= 17'h00000;
			lock_ready <= 1'b0;
		end
		else if (osc_en && !lock_ready)
		begin
			lock_cnt_r <= lock_cnt_r + 17'h00001;
			lock_ready <= lock_done; // RULE_10
		end
	end
endmodule

//--- src/scds_pkg.sv
// Constants, types and helper functions shared by the system clock divider and switchback block.
//
// Operation
// [RULE_01] Select routes raw oscillator, oscillator divided by 256, or multiplied oscillator.
// [RULE_02] Machine-cycle clock is system clock divided by four; peripherals use system clock.
// [RULE_03] Multiplier enable with select 00b multiplies by two or by four.
// [RULE_04] Select 11b gives slow mode: divide 256, machine cycle 1024 oscillator clocks.
// [RULE_05] New clock rate applies one machine cycle after the select write.
// [RULE_06] Software passes every select change through the 10 divide-by-4 setting.
// [RULE_07] Writes attempting a disallowed direct select transition are rejected, value kept.
// [RULE_08] Software engages multiplier in fixed order: check, clear, factor, enable, poll, 00.
// [RULE_09] Out-of-order engagement, or not from divide-by-4, leaves the select unchanged.
// [RULE_10] Lock-ready rises about 65,536 oscillator cycles after multiplier enable is set.
// [RULE_11] Multiplier engages the machine cycle after the 00 write following lock-ready.
// [RULE_12] Leaving multiplier mode needs only a plain select write.
// [RULE_13] With switchback enabled in slow mode, an event returns select to divide-by-4.
// [RULE_14] Only an enabled, acknowledged external interrupt triggers switchback.
// [RULE_15] An enabled serial receiver detecting a start bit triggers switchback.
// [RULE_16] A write to the serial transmit buffer triggers switchback.
// [RULE_17] Select writes are ignored while any serial port is active.
// [RULE_18] Reset gives divide-by-4 with multiplier and switchback enables cleared.
package scds_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_MODE     = 8'h00;
	localparam logic [7:0] ADDR_MCTL     = 8'h04;
	localparam logic [7:0] ADDR_STAT     = 8'h08;
	localparam int         MODE_SEL_LSB  = 6;
	localparam int         MODE_SWB_BIT  = 5;
	localparam int         MCTL_EN_BIT   = 0;
	localparam int         MCTL_FACT_BIT = 1;

	// ---------------------------------------------------------------
	// Select encodings and reset values
	// ---------------------------------------------------------------
	localparam logic [1:0] SEL_MULT  = 2'h0;
	localparam logic [1:0] SEL_DIV4A = 2'h1;
	localparam logic [1:0] SEL_DIV4  = 2'h2;
	localparam logic [1:0] SEL_SLOW  = 2'h3;
	localparam logic [1:0] RST_SEL   = SEL_DIV4;
	localparam logic       RST_SWB   = 1'b0;
	localparam logic       RST_EN    = 1'b0;
	localparam logic       RST_FACT  = 1'b0;

	// ---------------------------------------------------------------
	// Cycle counts
	// ---------------------------------------------------------------
	localparam int          OSC_PCLK_DIV = 4;
	localparam int          SLOW_DIV     = 256;
	localparam logic [10:0] PER_X4       = 11'h001;
	localparam logic [10:0] PER_X2       = 11'h002;
	localparam logic [10:0] PER_RAW      = 11'(OSC_PCLK_DIV);
	localparam logic [10:0] PER_SLOW     = 11'(OSC_PCLK_DIV * SLOW_DIV);
	localparam logic [1:0]  OSC_CNT_MAX  = 2'(OSC_PCLK_DIV - 1);
	localparam logic [1:0]  MC_CNT_MAX   = 2'h3;
	localparam int          LOCK_OSC_CYCLES = 65536;

	typedef enum logic [2:0]
	{
		SEQ_IDLE    = 3'b000,
		SEQ_CLEARED = 3'b001,
		SEQ_FACTOR  = 3'b010,
		SEQ_LOCKING = 3'b011,
		SEQ_READY   = 3'b100
	} scds_seq_t;

	// System tick period in pclk cycles for a select.
	function automatic logic [10:0] scds_period(input logic [1:0] sel, input logic mult_on,
		input logic factor);
		logic [10:0] p;
		p = PER_RAW;
		if (sel == SEL_SLOW)
			p = PER_SLOW;
		else if (sel == SEL_MULT && mult_on)
			p = factor ? PER_X4 : PER_X2;
		return p;
	endfunction

	// Allowed select transitions; all changes pass through divide-by-4.
	function automatic logic scds_sel_legal(input logic [1:0] cur, input logic [1:0] nxt,
		input logic mult_ok);
		logic ok;
		ok = 1'b0;
		if (nxt == cur)
			ok = 1'b1;
		else if (cur == SEL_DIV4)
			ok = (nxt == SEL_MULT) ? mult_ok : 1'b1;
		else
			ok = (nxt == SEL_DIV4);
		return ok;
	endfunction

endpackage

//--- src/scds_tick_gen.sv
// Divider that forms oscillator, system and machine-cycle tick enables.
`timescale 1ns/1ps
module scds_tick_gen
	import scds_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	scds_clk_if.gen  ck
);
	logic [1:0]  osc_cnt_r;
	logic [10:0] sys_cnt_r;
	logic [1:0]  mc_cnt_r;
	logic [10:0] period;
	wire         sys_tick;

	assign period   = scds_period(ck.sel_eff, ck.mult_on, ck.factor); // RULE_01
	assign sys_tick = (sys_cnt_r >= period - 11'h001);
	assign ck.osc_en = (osc_cnt_r == OSC_CNT_MAX);
	assign ck.sys_en = sys_tick;
	assign ck.mc_en  = sys_tick && (mc_cnt_r == MC_CNT_MAX); // RULE_02

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			osc_cnt_r <= 2'h0;
			sys_cnt_r <= 11'h000;
			mc_cnt_r  <= 2'h0;
		end
		else
		begin
			osc_cnt_r <= ck.osc_en ? 2'h0 : osc_cnt_r + 2'h1;
			sys_cnt_r <= sys_tick ? 11'h000 : sys_cnt_r + 11'h001; // RULE_04
			if (sys_tick)
				mc_cnt_r <= mc_cnt_r + 2'h1; // RULE_02
		end
	end
endmodule

//--- src/scds_top.sv
// System clock divide control with multiplier sequencing, switchback and APB registers.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module scds_top
	import scds_pkg::*;
#(
	parameter int LOCK_CYCLES = LOCK_OSC_CYCLES
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ring_osc_mode_flag,
	input  wire logic        ext_irq_ack,
	input  wire logic        ext_irq_enabled,
	input  wire logic        higher_prio_busy,
	input  wire logic        serial_rx_enabled,
	input  wire logic        serial_start_det,
	input  wire logic        serial_tx_buffer_wr,
	input  wire logic        serial_active,
	output logic             sys_clk_en,
	output logic             mc_clk_en,
	output logic             slow_clock_mode,
	output logic             multiplier_engaged,
	output logic             multiplier_lock_ready,
	output logic [1:0]       clock_divide_select_eff
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [1:0]  clock_divide_select_r;
	logic [1:0]  clock_divide_select_nxt;
	logic        switchback_enable_r;
	logic        switchback_enable_nxt;
	logic        multiplier_enable_r;
	logic        multiply_factor_select_r;
	logic [1:0]  sel_eff_r;
	logic [31:0] prdata_r;
	logic        mult_ok;
	logic        lock_ready;
	scds_seq_t   seq_state;

	scds_clk_if ck ();

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	wire         apb_setup  = psel && !penable;
	wire         apb_wr     = psel && penable && pwrite;
	wire         hit_mode   = (paddr == ADDR_MODE);
	wire         hit_mctl   = (paddr == ADDR_MCTL);
	wire         hit_stat   = (paddr == ADDR_STAT);
	wire         hit_any    = hit_mode || hit_mctl || hit_stat;
	wire         wr_mode    = apb_wr && hit_mode;
	wire         wr_mctl    = apb_wr && hit_mctl;
	wire [1:0]   wr_sel     = pwdata[MODE_SEL_LSB +: 2];
	wire         wr_en_bit  = pwdata[MCTL_EN_BIT];

	// ---------------------------------------------------------------
	// Select write qualification
	// ---------------------------------------------------------------
	wire sel_legal = scds_sel_legal(clock_divide_select_r, wr_sel, mult_ok); // RULE_07
	wire sel_take  = wr_mode && sel_legal && !serial_active; // RULE_17
	wire engage    = sel_take && (wr_sel == SEL_MULT) &&
		(clock_divide_select_r != SEL_MULT); // RULE_11

	// ---------------------------------------------------------------
	// Switchback events
	// ---------------------------------------------------------------
	wire sb_irq  = ext_irq_ack && ext_irq_enabled && !higher_prio_busy; // RULE_14
	wire sb_rx   = serial_start_det && serial_rx_enabled; // RULE_15
	wire sb_tx   = serial_tx_buffer_wr; // RULE_16
	wire sb_fire = switchback_enable_r && (clock_divide_select_r == SEL_SLOW) &&
		(sb_irq || sb_rx || sb_tx); // RULE_13

	// Switchback wins over a software select write in the same cycle.
	always_comb
	begin
		clock_divide_select_nxt = clock_divide_select_r;
		if (sb_fire)
			clock_divide_select_nxt = SEL_DIV4; // RULE_13
		else if (sel_take)
			clock_divide_select_nxt = wr_sel; // RULE_12
		switchback_enable_nxt = wr_mode ? pwdata[MODE_SWB_BIT] : switchback_enable_r;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clock_divide_select_r <= RST_SEL; // RULE_18
			switchback_enable_r   <= RST_SWB; // RULE_18
		end
		else
		begin
			clock_divide_select_r <= clock_divide_select_nxt;
			switchback_enable_r   <= switchback_enable_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Multiplier control register
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			multiplier_enable_r      <= RST_EN; // RULE_18
			multiply_factor_select_r <= RST_FACT;
		end
		else if (wr_mctl)
		begin
			multiplier_enable_r      <= wr_en_bit;
			multiply_factor_select_r <= pwdata[MCTL_FACT_BIT]; // RULE_03
		end
	end

	// ---------------------------------------------------------------
	// Effective selection, taken over at a machine-cycle boundary
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sel_eff_r <= RST_SEL;
		else if (ck.mc_en)
			sel_eff_r <= clock_divide_select_r; // RULE_05
	end

	assign ck.sel_eff = sel_eff_r;
	assign ck.mult_on = (sel_eff_r == SEL_MULT) && multiplier_enable_r && lock_ready; // RULE_03
	assign ck.factor  = multiply_factor_select_r;

	// ---------------------------------------------------------------
	// Submodules
	// ---------------------------------------------------------------
	scds_tick_gen u_tick
	(
		.pclk    (pclk),
		.presetn (presetn),
		.ck      (ck.gen)
	);

	scds_mult_seq #(
		.LOCK_CYCLES (LOCK_CYCLES)
	) u_seq
	(
		.pclk       (pclk),
		.presetn    (presetn),
		.mctl_wr    (wr_mctl),
		.wr_en_bit  (wr_en_bit),
		.mult_en    (multiplier_enable_r),
		.sel_cur    (clock_divide_select_r),
		.ring_flag  (ring_osc_mode_flag),
		.osc_en     (ck.osc_en),
		.engage     (engage),
		.mult_ok    (mult_ok),
		.lock_ready (lock_ready),
		.state      (seq_state)
	);

	// ---------------------------------------------------------------
	// Read data, captured in the setup cycle
	// ---------------------------------------------------------------
	wire [31:0] rd_mode = {24'h000000, clock_divide_select_r, switchback_enable_r, 5'h00};
	wire [31:0] rd_mctl = {30'h00000000, multiply_factor_select_r, multiplier_enable_r};
	wire [31:0] rd_stat = {23'h000000, seq_state, serial_active, sel_eff_r,
		(sel_eff_r == SEL_SLOW), ring_osc_mode_flag, lock_ready};
	wire [31:0] rd_mux  = hit_mode ? rd_mode :
		hit_mctl ? rd_mctl :
		hit_stat ? rd_stat : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= 32'h00000000;
		else if (apb_setup && !pwrite)
			prdata_r <= rd_mux;
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign prdata                  = prdata_r;
	assign pready                  = 1'b1;
	assign pslverr                 = psel && penable && !hit_any;
	assign sys_clk_en              = ck.sys_en; // RULE_02
	assign mc_clk_en               = ck.mc_en; // RULE_02
	assign slow_clock_mode         = (sel_eff_r == SEL_SLOW); // RULE_04
	assign multiplier_engaged      = ck.mult_on; // RULE_11
	assign multiplier_lock_ready   = lock_ready;
	assign clock_divide_select_eff = sel_eff_r;

endmodule
